// File: asp_uart.sv
// Asynchronous serial port with 8/9-bit framing, buffered receive and
// multiprocessor address filtering, reached over APB.
// Assumes APB master on clk; pins are asynchronous and get synchronised.
`timescale 1ns/100ps
module asp_uart (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        serialRxPin,
   output logic             serialTxPin,
   input  wire logic        extOscClk,
   input  wire logic        timerExtInput,
   output logic             irq
);
   typedef struct packed {
      logic                 frameModeSelect;
      logic                 multiprocEnableBit;
      logic                 rxEnableBit;
      logic                 txNinthBitCtrl;
      logic                 rxNinthBitFlag;
      logic                 txDoneFlag;
      logic                 rxDoneFlag;
      logic [7:0]           rxBuf;
      logic [7:0]           reload;
      logic                 run;
      logic [2:0]           clkSel;
      logic                 irqEn;
      logic [31:0]          prdata;
      logic                 pready;
      logic                 pslverr;
      logic                 irq;
      logic [5:0]           pre;
      logic [2:0]           extCnt;
      logic [2:0]           rxSync;
      logic [2:0]           oscSync;
      logic [2:0]           extInSync;
      asp_pkg::asp_tx_e     txState;
      logic [7:0]           txShift;
      logic [3:0]           txIdx;
      logic                 txPin;
      logic                 txNinth;
      logic                 txMode;
      asp_pkg::asp_rx_e     rxState;
      logic [7:0]           rxShift;
      logic [3:0]           rxIdx;
      logic                 rxNinth;
   } asp_uart_s;

   localparam asp_uart_s RESET_STATE = '{
      frameModeSelect: asp_pkg::CTRL_RESET[asp_pkg::CTL_MODE],
      txState:         asp_pkg::TX_IDLE,
      rxState:         asp_pkg::RX_IDLE,
      reload:          asp_pkg::RELOAD_RESET,
      txPin:           1'b1,
      rxSync:          3'h7,
      default:         '0
   };

   asp_uart_s q;
   asp_uart_s d;

   asp_tmr_if txTif ();
   asp_tmr_if rxTif ();

   logic        setup;
   logic        wrAcc;
   logic        addrHit;
   logic [5:0]  preLimit;
   logic        oscRise;
   logic        extInFall;
   logic        baudTick;
   logic        startDet;
   logic        rxBit;
   logic        rxNinthCand;
   logic        rxLoad;
   logic [7:0]  ctrlByte;
   logic [31:0] rdData;

   assign setup   = psel && !penable;
   assign wrAcc   = psel && penable && q.pready && pwrite;
   assign addrHit = paddr == asp_pkg::ADDR_DATA || paddr == asp_pkg::ADDR_CTRL ||
                    paddr == asp_pkg::ADDR_BAUD || paddr == asp_pkg::ADDR_STATUS;

   // Timer clock source selection
   assign preLimit = (q.clkSel == asp_pkg::CS_DIV4)  ? asp_pkg::PRE_4_MAX  :
                     (q.clkSel == asp_pkg::CS_DIV12) ? asp_pkg::PRE_12_MAX :
                     (q.clkSel == asp_pkg::CS_DIV48) ? asp_pkg::PRE_48_MAX : 6'h00;
   assign oscRise  = q.oscSync[1] && !q.oscSync[2];
   assign extInFall = !q.extInSync[1] && q.extInSync[2];
   assign baudTick = (q.clkSel <= asp_pkg::CS_DIV48)  ? (q.pre == preLimit) :
                     (q.clkSel == asp_pkg::CS_EXTOSC) ?
                        (oscRise && q.extCnt == asp_pkg::EXT_DIV_MAX) :
                     (q.clkSel == asp_pkg::CS_EXTIN)  ? extInFall : 1'b0;

   // Falling edge on the idle line, only while receive is enabled
   assign startDet = q.rxState == asp_pkg::RX_IDLE && q.rxEnableBit && q.run &&
                     !q.rxSync[1] && q.rxSync[2];

   assign txTif.tick    = baudTick;
   assign txTif.run     = q.run;
   assign txTif.restart = 1'b0;
   assign txTif.reload  = q.reload;
   assign rxTif.tick    = baudTick;
   assign rxTif.run     = q.run;
   assign rxTif.restart = startDet;
   assign rxTif.reload  = q.reload;

   asp_reload_timer uTxTimer (
      .clk   (clk),
      .rst_n (rst_n),
      .tif   (txTif)
   );

   asp_reload_timer uRxTimer (
      .clk   (clk),
      .rst_n (rst_n),
      .tif   (rxTif)
   );

   // Ninth candidate is the ninth bit in 9-bit mode, else the stop bit
   assign rxBit       = q.rxSync[1];
   assign rxNinthCand = q.frameModeSelect ? q.rxNinth : rxBit;
   assign rxLoad      = q.rxState == asp_pkg::RX_STOP && rxTif.midTick &&
                        !q.rxDoneFlag && (!q.multiprocEnableBit || rxNinthCand);

   assign ctrlByte = {q.frameModeSelect, 1'b1, q.multiprocEnableBit, q.rxEnableBit,
                      q.txNinthBitCtrl, q.rxNinthBitFlag, q.txDoneFlag, q.rxDoneFlag};

   // Transmit register has no read path
   assign rdData = (paddr == asp_pkg::ADDR_DATA) ? {24'h00_0000, q.rxBuf} :
                   (paddr == asp_pkg::ADDR_CTRL) ? {24'h00_0000, ctrlByte} :
                   (paddr == asp_pkg::ADDR_BAUD) ?
                      {19'h0_0000, q.irqEn, q.clkSel, q.run, q.reload} :
                   (paddr == asp_pkg::ADDR_STATUS) ?
                      {22'h00_0000, q.rxState != asp_pkg::RX_IDLE,
                       q.txState != asp_pkg::TX_IDLE, txTif.count} : 32'h0000_0000;

   always_comb begin
      d         = q;
      d.rxSync  = {q.rxSync[1:0], serialRxPin};
      d.oscSync = {q.oscSync[1:0], extOscClk};
      d.extInSync = {q.extInSync[1:0], timerExtInput};
      d.pre     = (!q.run || q.pre >= preLimit) ? 6'h00 : q.pre + 6'h01;
      d.extCnt  = oscRise ? q.extCnt + 3'h1 : q.extCnt;

      // Zero-wait slave: answer registered in setup, valid in access phase
      d.pready  = setup;
      d.pslverr = setup && !addrHit;
      d.prdata  = (setup && !pwrite) ? rdData : 32'h0000_0000;

      if (wrAcc && paddr == asp_pkg::ADDR_CTRL) begin
         d.frameModeSelect    = pwdata[asp_pkg::CTL_MODE];
         d.multiprocEnableBit = pwdata[asp_pkg::CTL_MCE];
         d.rxEnableBit        = pwdata[asp_pkg::CTL_REN];
         d.txNinthBitCtrl     = pwdata[asp_pkg::CTL_TB8];
         d.rxNinthBitFlag     = pwdata[asp_pkg::CTL_RB8];
         d.txDoneFlag         = pwdata[asp_pkg::CTL_TI];
         d.rxDoneFlag         = pwdata[asp_pkg::CTL_RI];
      end
      if (wrAcc && paddr == asp_pkg::ADDR_BAUD) begin
         d.reload = pwdata[7:0];
         d.run    = pwdata[asp_pkg::BD_RUN];
         d.clkSel = pwdata[asp_pkg::BD_SEL_LO +: 3];
         d.irqEn  = pwdata[asp_pkg::BD_IEN];
      end

      // Transmitter, stepped by the divided transmit overflow
      case (q.txState)
         asp_pkg::TX_IDLE: begin
            // A write while busy is dropped; no transmit holding register
            if (wrAcc && paddr == asp_pkg::ADDR_DATA) begin
               d.txShift = pwdata[7:0];
               d.txNinth = q.txNinthBitCtrl;
               d.txMode  = q.frameModeSelect;
               d.txState = asp_pkg::TX_START;
            end
         end
         asp_pkg::TX_START: begin
            if (txTif.bitTick) begin
               d.txPin   = 1'b0;
               d.txIdx   = 4'h0;
               d.txState = asp_pkg::TX_DATA;
            end
         end
         asp_pkg::TX_DATA: begin
            if (txTif.bitTick) begin
               if (q.txIdx != asp_pkg::DATA_BITS) begin
                  d.txPin   = q.txShift[0];
                  d.txShift = {1'b0, q.txShift[7:1]};
                  d.txIdx   = q.txIdx + 4'h1;
               end else if (q.txMode) begin
                  d.txPin   = q.txNinth;
                  d.txState = asp_pkg::TX_NINTH;
               end else begin
                  d.txPin      = 1'b1;
                  d.txDoneFlag = 1'b1;
                  d.txState    = asp_pkg::TX_STOP;
               end
            end
         end
         asp_pkg::TX_NINTH: begin
            if (txTif.bitTick) begin
               d.txPin      = 1'b1;
               d.txDoneFlag = 1'b1;
               d.txState    = asp_pkg::TX_STOP;
            end
         end
         asp_pkg::TX_STOP: begin
            if (txTif.bitTick) begin
               d.txState = asp_pkg::TX_IDLE;
            end
         end
         default: begin
            d.txPin   = 1'b1;
            d.txState = asp_pkg::TX_IDLE;
         end
      endcase

      // Receiver on its own timer; samples on mid-bit overflows
      case (q.rxState)
         asp_pkg::RX_IDLE: begin
            if (startDet) begin
               d.rxState = asp_pkg::RX_START;
            end
         end
         asp_pkg::RX_START: begin
            if (rxTif.midTick) begin
               // Glitch shorter than half a bit is not a start
               d.rxState = rxBit ? asp_pkg::RX_IDLE : asp_pkg::RX_DATA;
               d.rxIdx   = 4'h0;
            end
         end
         asp_pkg::RX_DATA: begin
            if (rxTif.midTick) begin
               d.rxShift = {rxBit, q.rxShift[7:1]};
               d.rxIdx   = q.rxIdx + 4'h1;
               if (q.rxIdx == asp_pkg::DATA_BITS - 4'h1) begin
                  d.rxState = q.frameModeSelect ? asp_pkg::RX_NINTH : asp_pkg::RX_STOP;
               end
            end
         end
         asp_pkg::RX_NINTH: begin
            if (rxTif.midTick) begin
               d.rxNinth = rxBit;
               d.rxState = asp_pkg::RX_STOP;
            end
         end
         asp_pkg::RX_STOP: begin
            if (rxTif.midTick) begin
               // Buffer only moves on a passing load; overrun keeps old byte
               if (rxLoad) begin
                  d.rxBuf          = q.rxShift;
                  d.rxNinthBitFlag = rxNinthCand;
                  d.rxDoneFlag     = 1'b1;
               end
               d.rxState = asp_pkg::RX_IDLE;
            end
         end
         default: begin
            d.rxState = asp_pkg::RX_IDLE;
         end
      endcase

      d.irq = d.irqEn && (d.txDoneFlag || d.rxDoneFlag);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RESET_STATE;
      end else begin
         q <= d;
      end
   end

   assign prdata      = q.prdata;
   assign pready      = q.pready;
   assign pslverr     = q.pslverr;
   assign serialTxPin = q.txPin;
   assign irq         = q.irq;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic ctrlWr;
   assign ctrlWr = wrAcc && paddr == asp_pkg::ADDR_CTRL;

   property p_read_rx_buf;
      setup && !pwrite && paddr == asp_pkg::ADDR_DATA
         |=> prdata == {24'h00_0000, $past(q.rxBuf)} && pready;
   endproperty
   a_read_rx_buf: assert property (p_read_rx_buf)
      else $error("data read not rx buffer");

   property p_flags_sticky;
      (q.txDoneFlag || q.rxDoneFlag) && !ctrlWr
         |=> (q.txDoneFlag >= $past(q.txDoneFlag)) && (q.rxDoneFlag >= $past(q.rxDoneFlag));
   endproperty
   a_flags_sticky: assert property (p_flags_sticky)
      else $error("flag cleared by hardware");

   property p_irq_follows;
      $rose(q.txDoneFlag || q.rxDoneFlag) && q.irqEn |-> irq;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("interrupt not raised");

   property p_rx_restart;
      startDet |=> rxTif.count == $past(q.reload) ##1 q.rxState == asp_pkg::RX_START;
   endproperty
   a_rx_restart: assert property (p_rx_restart) else $error("rx timer not reloaded");

   property p_ti_at_stop;
      $rose(q.txDoneFlag) && !$past(ctrlWr) |-> serialTxPin && q.txState == asp_pkg::TX_STOP;
   endproperty
   a_ti_at_stop: assert property (p_ti_at_stop) else $error("tx done not at stop");

   property p_start_low;
      q.txState == asp_pkg::TX_START && txTif.bitTick |=> !serialTxPin && q.txIdx == 4'h0;
   endproperty
   a_start_low: assert property (p_start_low) else $error("start bit not low");

   property p_ninth_sent;
      q.txState == asp_pkg::TX_DATA && q.txIdx == asp_pkg::DATA_BITS && q.txMode &&
      txTif.bitTick |=> serialTxPin == $past(q.txNinth);
   endproperty
   a_ninth_sent: assert property (p_ninth_sent) else $error("ninth bit wrong");

   property p_rx_disabled;
      q.rxState == asp_pkg::RX_IDLE && !q.rxEnableBit |=> q.rxState == asp_pkg::RX_IDLE;
   endproperty
   a_rx_disabled: assert property (p_rx_disabled) else $error("rx while disabled");

   property p_overrun_keeps;
      q.rxDoneFlag && !ctrlWr |=> $stable(q.rxBuf) && $stable(q.rxNinthBitFlag);
   endproperty
   a_overrun_keeps: assert property (p_overrun_keeps)
      else $error("rx buffer overwritten");

   property p_rx_load;
      rxLoad |=> q.rxDoneFlag && q.rxBuf == $past(q.rxShift) &&
                 q.rxNinthBitFlag == $past(rxNinthCand);
   endproperty
   a_rx_load: assert property (p_rx_load) else $error("rx load wrong");

   property p_mode_ninth;
      q.rxState == asp_pkg::RX_DATA && q.rxIdx == 4'h7 && rxTif.midTick && q.frameModeSelect
         |=> q.rxState == asp_pkg::RX_NINTH;
   endproperty
   a_mode_ninth: assert property (p_mode_ninth) else $error("9-bit mode ignored");

   c_tx_ninth: cover property (q.txState == asp_pkg::TX_NINTH ##[1:1000] $rose(q.txDoneFlag));
   c_rx_load:  cover property (rxLoad);
   c_rx_filtered: cover property (q.rxState == asp_pkg::RX_STOP && rxTif.midTick && !rxLoad);
   c_false_start: cover property (q.rxState == asp_pkg::RX_START && rxTif.midTick && rxBit);
endmodule

// File: asp_pkg.sv
// Shared constants of the asynchronous serial port: register map,
// control field positions, reset values, prescale counts and state codes.
// Assumes a 32-bit APB slave with one register per aligned word.
package asp_pkg;

   localparam logic [11:0] ADDR_DATA   = 12'h000;
   localparam logic [11:0] ADDR_CTRL   = 12'h004;
   localparam logic [11:0] ADDR_BAUD   = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00C;

   // Control register field positions
   localparam int CTL_MODE = 7;
   localparam int CTL_FIX  = 6;
   localparam int CTL_MCE  = 5;
   localparam int CTL_REN  = 4;
   localparam int CTL_TB8  = 3;
   localparam int CTL_RB8  = 2;
   localparam int CTL_TI   = 1;
   localparam int CTL_RI   = 0;
   localparam logic [7:0] CTRL_RESET = 8'h40;

   // Baud register: reload in [7:0], run, source select, interrupt enable
   localparam int BD_RUN    = 8;
   localparam int BD_SEL_LO = 9;
   localparam int BD_IEN    = 12;
   localparam logic [7:0] RELOAD_RESET = 8'h00;

   // Status register fields above the live timer count in [7:0]
   localparam int ST_TXBUSY = 8;
   localparam int ST_RXBUSY = 9;

   // Timer clock sources
   localparam logic [2:0] CS_SYS    = 3'h0;
   localparam logic [2:0] CS_DIV4   = 3'h1;
   localparam logic [2:0] CS_DIV12  = 3'h2;
   localparam logic [2:0] CS_DIV48  = 3'h3;
   localparam logic [2:0] CS_EXTOSC = 3'h4;
   localparam logic [2:0] CS_EXTIN  = 3'h5;

   // Prescaler terminal counts (divisor minus one)
   localparam logic [5:0] PRE_4_MAX  = 6'h03;
   localparam logic [5:0] PRE_12_MAX = 6'h0B;
   localparam logic [5:0] PRE_48_MAX = 6'h2F;
   localparam logic [2:0] EXT_DIV_MAX = 3'h7;

   localparam logic [3:0] DATA_BITS = 4'h8;
   localparam logic [7:0] TMR_TOP   = 8'hFF;

   typedef enum logic [4:0] {
      TX_IDLE  = 5'h01,
      TX_START = 5'h02,
      TX_DATA  = 5'h04,
      TX_NINTH = 5'h08,
      TX_STOP  = 5'h10
   } asp_tx_e;

   typedef enum logic [4:0] {
      RX_IDLE  = 5'h01,
      RX_START = 5'h02,
      RX_DATA  = 5'h04,
      RX_NINTH = 5'h08,
      RX_STOP  = 5'h10
   } asp_rx_e;

endpackage

// File: asp_tmr_if.sv
// Link between the port logic and one 8-bit auto-reload baud timer.
// Assumes all signals are on the single system clock.
`timescale 1ns/100ps
interface asp_tmr_if;
   logic       tick;
   logic       run;
   logic       restart;
   logic [7:0] reload;
   logic [7:0] count;
   logic       midTick;
   logic       bitTick;

   modport ctrl (output tick, run, restart, reload, input count, midTick, bitTick);
   modport tmr  (input tick, run, restart, reload, output count, midTick, bitTick);
endinterface

// File: asp_reload_timer.sv
// One 8-bit auto-reload baud timer with a divide-by-two overflow phase.
// Assumes tick is a one-cycle enable on clk; restart wins over counting.
`timescale 1ns/100ps
module asp_reload_timer (
   input wire logic clk,
   input wire logic rst_n,
   asp_tmr_if.tmr   tif
);
   typedef struct packed {
      logic [7:0] count;
      logic       phase;
      logic       midTick;
      logic       bitTick;
   } asp_tmr_s;

   asp_tmr_s q;
   asp_tmr_s d;

   always_comb begin
      d         = q;
      d.midTick = 1'b0;
      d.bitTick = 1'b0;
      if (tif.restart) begin
         d.count = tif.reload;
         d.phase = 1'b0;
      end else if (tif.run && tif.tick) begin
         if (q.count == asp_pkg::TMR_TOP) begin
            d.count   = tif.reload;
            d.phase   = ~q.phase;
            // Odd overflows fall mid-bit, even ones end a bit
            d.midTick = ~q.phase;
            d.bitTick = q.phase;
         end else begin
            d.count = q.count + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tif.count   = q.count;
   assign tif.midTick = q.midTick;
   assign tif.bitTick = q.bitTick;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_reload_on_top;
      tif.run && tif.tick && !tif.restart && q.count == asp_pkg::TMR_TOP
         |=> q.count == $past(tif.reload) && (q.midTick != q.bitTick);
   endproperty
   a_reload_on_top: assert property (p_reload_on_top)
      else $error("timer reload missed");
endmodule

// File: asp_node.sv
// Remote serial node: sends frames on the port's receive pin and
// captures frames from its transmit pin. Assumes BIT clk cycles per bit.
`timescale 1ns/100ps
module asp_node #(
   parameter int BIT = 32
) (
   input  wire logic clk,
   input  wire logic txLine,
   output logic      rxLine
);
   logic [9:0] heard;
   int         nHeard;

   initial begin
      rxLine = 1'b1;
      nHeard = 0;
   end

   // Stop bit leaves the line high, which is also its idle level
   task automatic send(input logic [7:0] d, input logic nine, input logic useNine);
      logic [10:0] f;
      f = useNine ? {1'b1, nine, d, 1'b0} : {2'b11, d, 1'b0};
      for (int i = 0; i < (useNine ? 11 : 10); i++) begin
         rxLine <= f[i];
         repeat (BIT) @(posedge clk);
      end
   endtask

   // Samples mid-bit; ten samples cover data plus ninth or stop and stop
   always begin
      @(negedge txLine);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         repeat (BIT) @(posedge clk);
         heard[i] = txLine;
      end
      nHeard++;
   end
endmodule

// File: testbench.sv
// Self-checking bench: APB register traffic and serial frames both ways.
// Assumes reload 0xF0 from the system clock, so one bit is 32 clk.
`timescale 1ns/100ps
module testbench;
   logic        clk;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        txPin;
   logic        rxPin;
   logic        err;
   logic        extOscClk;
   logic        timerExtInput;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic [31:0] rd;
   int          n_fail;
   int          checks_done;
   int          cyc;

   asp_uart dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serialRxPin(rxPin), .serialTxPin(txPin), .extOscClk(extOscClk),
      .timerExtInput(timerExtInput), .irq(irq));
   asp_node #(.BIT(32)) node (.clk(clk), .txLine(txPin), .rxLine(rxPin));

   always #2.5 clk = ~clk;
   always #7 extOscClk = ~extOscClk;
   always #13 timerExtInput = ~timerExtInput;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         n_fail++;
         stop_test();
      end
   end

   task automatic stop_test();
      if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // Bounded, since a dead transmitter must not hang the run
   task automatic send_wait(input logic [31:0] ctl, input logic [7:0] d);
      int n0;
      int k;
      n0 = node.nHeard;
      k = 0;
      apb(asp_pkg::ADDR_CTRL, 1'b1, ctl);
      apb(asp_pkg::ADDR_DATA, 1'b1, {24'h0, d});
      apb(asp_pkg::ADDR_DATA, 1'b0, '0);
      chk(rd, 32'h0000_0000);
      while (node.nHeard == n0 && k < 2000) begin
         @(posedge clk);
         k++;
      end
      chk({31'h0, node.nHeard != n0}, 32'h0000_0001);
   endtask

   task automatic t_tx();
      send_wait(32'h0000_0010, 8'hA5);
      chk({22'h0, node.heard}, 32'h0000_03A5);
      apb(asp_pkg::ADDR_CTRL, 1'b0, '0);
      chk(rd, 32'h0000_0052);
      chk({31'h0, irq}, 32'h0000_0001);
      apb(asp_pkg::ADDR_CTRL, 1'b1, 32'h0000_0010);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0000_0000);
      send_wait(32'h0000_0098, 8'h5A);
      chk({22'h0, node.heard}, 32'h0000_035A);
   endtask

   task automatic t_rx();
      apb(asp_pkg::ADDR_CTRL, 1'b1, 32'h0000_0010);
      node.send(8'h3C, 1'b0, 1'b0);
      node.send(8'h77, 1'b0, 1'b0);
      apb(asp_pkg::ADDR_DATA, 1'b0, '0);
      chk(rd, 32'h0000_003C);
      apb(asp_pkg::ADDR_CTRL, 1'b0, '0);
      chk(rd, 32'h0000_0055);
      apb(asp_pkg::ADDR_CTRL, 1'b1, 32'h0000_00B0);
      node.send(8'h11, 1'b0, 1'b1);
      apb(asp_pkg::ADDR_CTRL, 1'b0, '0);
      chk(rd, 32'h0000_00F0);
      node.send(8'h42, 1'b1, 1'b1);
      apb(asp_pkg::ADDR_DATA, 1'b0, '0);
      chk(rd, 32'h0000_0042);
      apb(asp_pkg::ADDR_CTRL, 1'b0, '0);
      chk(rd, 32'h0000_00F5);
      apb(asp_pkg::ADDR_CTRL, 1'b1, 32'h0000_0090);
      node.send(8'h24, 1'b0, 1'b1);
      apb(asp_pkg::ADDR_DATA, 1'b0, '0);
      chk(rd, 32'h0000_0024);
      apb(asp_pkg::ADDR_CTRL, 1'b1, 32'h0000_0000);
      node.send(8'h99, 1'b0, 1'b0);
      apb(asp_pkg::ADDR_CTRL, 1'b0, '0);
      chk(rd, 32'h0000_0040);
   endtask

   task automatic t_src();
      logic [7:0] c0;
      for (int s = 0; s < 6; s++) begin
         apb(asp_pkg::ADDR_BAUD, 1'b1, 32'h0000_11F0 | (32'(s) << 9));
         apb(asp_pkg::ADDR_STATUS, 1'b0, '0);
         c0 = rd[7:0];
         chk({31'h0, c0 >= 8'hF0}, 32'h0000_0001);
         // 53 cycles apart: at least one /48 tick, never a full /4 wrap
         repeat (50) @(posedge clk);
         apb(asp_pkg::ADDR_STATUS, 1'b0, '0);
         chk({31'h0, rd[7:0] !== c0}, 32'h0000_0001);
      end
   endtask

   initial begin
      clk = 1'b0;
      extOscClk = 1'b0;
      timerExtInput = 1'b0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      n_fail = 0;
      checks_done = 0;
      cyc = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(asp_pkg::ADDR_CTRL, 1'b0, '0);
      chk(rd, {24'h0, asp_pkg::CTRL_RESET});
      apb(12'h010, 1'b0, '0);
      chk({31'h0, err}, 32'h0000_0001);
      apb(asp_pkg::ADDR_BAUD, 1'b1, 32'h0000_11F0);
      t_tx();
      t_rx();
      t_src();
      stop_test();
   end
endmodule
